// File: common/cfm_pkg.sv
package cfm_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] OFS_CTRL = 8'h00; // monitor enable, spi mode, delta select
  localparam logic [7:0] OFS_STATUS = 8'h04; // init done, osc flags, fault line
  localparam logic [7:0] OFS_REG_FAULT = 8'h08; // regulator uv/ov latches, clear on read
  localparam logic [7:0] OFS_SELFTEST = 8'h0C; // comparator self-test latches, clear on read
  localparam logic [7:0] OFS_GPIO_OUT = 8'h10; // pin output value and output enable
  localparam logic [7:0] OFS_SHORT = 8'h14; // pin short latches, clear on read
  localparam logic [7:0] OFS_OPEN = 8'h18; // open-wire latches, clear on read
  localparam logic [7:0] OFS_THR_FAULT = 8'h1C; // high/low threshold latches, clear on read
  localparam logic [7:0] OFS_FAST_FAULT = 8'h20; // fast charge latches, clear on read
  localparam logic [7:0] OFS_MASK = 8'h24; // threshold mask and fast charge mask
  localparam logic [7:0] OFS_ANALOG = 8'h28; // analog-input select per pin
  localparam logic [7:0] OFS_THR_BASE = 8'h40; // 7 words: pin 3..9 high/low thresholds
  // control field positions
  localparam int CTRL_CLK_MON_EN = 0;
  localparam int CTRL_SPI_MODE = 1;
  localparam int CTRL_DELTA_LSB = 4;
  localparam int THR_LOW_LSB = 0;
  localparam int THR_HIGH_LSB = 16;
  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [15:0] RST_THR_HIGH = 16'hFFFF;
  localparam logic [15:0] RST_THR_LOW = 16'h0000;
  // timing: 20 MHz clock, 50 ns period
  localparam int CLK_PERIOD_NS = 50;
  localparam int ECHO_FILT_NS = 1000; // output_echo_filter_time
  localparam int ECHO_FILT_CYC = (ECHO_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REG_FILT_NS = 2000; // regulator comparator filter time
  localparam int REG_FILT_CYC = (REG_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_SET_NS = 5000; // open-wire settling time
  localparam int OPEN_SET_CYC = (OPEN_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREQ_DIFF_PCT = 15; // clock check limit in percent
  localparam int CLK_WIN = 256; // main clock window length in redundant ticks
  localparam int STUCK_CYC = 64; // standby osc silent cycles counted as stuck
  localparam int INIT_CYC = 16; // cycles until monitor reports active
  localparam logic [15:0] OPEN_THR = 16'h0400; // open_wire_threshold
  // regulator bit index
  localparam int REG_SENSOR = 0; // sensor_reference_regulator
  localparam int REG_COMM = 1; // communication_regulator
  localparam int REG_CORE = 2; // core_regulator
  // analog conversion result from the conversion routine
  typedef struct packed {
    logic valid; // one-cycle strobe
    logic open_test; // conversion done with pulldown on, fastest_filter_option
    logic [3:0] pin; // pin number 3..9
    logic [15:0] code; // converted voltage
  } cfm_conv_t;
  // regulator comparator inputs
  typedef struct packed {
    logic [2:0] uv;
    logic [2:0] ov;
  } cfm_regcmp_t;
endpackage

// File: design/cfm_monitor.sv
`timescale 1ns/100ps
// How it works
// - monitor runs once enabled, reports init done
// - main vs redundant clock over 15% flags
// - standby oscillator always watched for stuck
// - stuck standby clock kills all balancing
// - normal mode keeps serial, low power no wake
// - filtered regulator uv/ov latches, raises fault
// - core ov stops boot and balance, uv balance
// - routine can self-test regulator comparators
// - self-test fail latches, faults, forces override
// - output echo mismatch beyond filter is short
// - short latches, faults, tristates that pin
// - short latch cleared by host read
// - no short check on pin 9 as sdo
// - open: pulldown, settle, fast convert, compare
// - open check only pins 3-9 analog
// - open latches, faults, forces override
// - per-pin high, low thresholds and mask
// - fast threshold is low plus 16 times delta
// - unmasked out-of-range latches, faults, override
// - masked pin sets no high/low latch
// - below fast threshold latches unless masked
module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int NPIN = 9
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic red_osc_tick, // redundant oscillator divided, async
  input wire logic main_osc_tick, // main oscillator divided, async
  input wire logic standby_osc, // standby oscillator divided, async
  input wire cfm_pkg::cfm_regcmp_t reg_cmp, // async comparator outputs
  input wire logic selftest_req, // routine requests comparator self test
  input wire logic [2:0] selftest_bad, // comparator did not flip in test
  input wire logic low_power, // device in a low power mode
  input wire logic [NPIN-1:0] pin_echo, // schmitt trigger echo, async
  input wire cfm_pkg::cfm_conv_t conv, // conversion results
  output logic [NPIN-1:0] pin_out, // pin output level
  output logic [NPIN-1:0] pin_oe, // pin output enable
  output logic [NPIN-1:0] open_pulldown, // open-wire pulldown current on
  output logic open_req, // ask for a fast open-wire conversion
  output logic fault_line, // shared fault line
  output logic config_override, // force routine into config override
  output logic balance_en, // balancing drivers allowed
  output logic bootstrap_en, // bootstrap allowed
  output logic wake_en // wakeup path usable
);
  import cfm_pkg::*;

  localparam int FP = 3; // first pin with analog diagnostics

  // two-flop synchroniser for all async inputs
  localparam int SW = 3 + 6 + NPIN;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {pin_echo, reg_cmp, standby_osc, main_osc_tick, red_osc_tick};
      sync2 <= sync1;
    end
  end
  logic red_s, main_s, stby_s;
  logic [2:0] uv_s, ov_s;
  logic [NPIN-1:0] echo_s;
  assign {echo_s, uv_s, ov_s, stby_s, main_s, red_s} = sync2;

  // edge detectors on synced ticks
  logic red_d, main_d, stby_d;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      red_d <= 1'b0;
      main_d <= 1'b0;
      stby_d <= 1'b0;
    end
    else
    begin
      red_d <= red_s;
      main_d <= main_s;
      stby_d <= stby_s;
    end
  end
  wire red_edge = red_s & ~red_d;
  wire main_edge = main_s & ~main_d;

  // software registers
  logic [31:0] ctrl;
  logic [NPIN-1:0] out_val, out_en, analog_sel;
  logic [NPIN-1:0] thr_mask, fast_mask;
  logic [15:0] thr_high [FP:NPIN];
  logic [15:0] thr_low [FP:NPIN];
  // fault latches
  logic [2:0] uv_flag, ov_flag, bist_flag;
  logic osc_fail, stby_fail;
  logic [NPIN-1:0] short_flag, open_flag, high_flag, low_flag, fast_flag;

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  // read of a clear-on-read register
  function automatic logic rd_at(input logic [7:0] a, input logic [7:0] ofs, input logic r);
    rd_at = r && (a == ofs);
  endfunction
  // fast charge threshold, saturating
  function automatic logic [15:0] fast_thr(input logic [15:0] low, input logic [3:0] sel);
    logic [16:0] s;
    s = {1'b0, low} + {9'h000, sel, 4'h0};
    fast_thr = s[16] ? 16'hFFFF : s[15:0];
  endfunction

  // control and output register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= RST_CTRL;
      out_val <= '0;
      out_en <= '0;
      analog_sel <= '0;
      thr_mask <= '0;
      fast_mask <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        OFS_CTRL: ctrl <= pwdata;
        OFS_GPIO_OUT:
        begin
          out_val <= pwdata[NPIN-1:0];
          out_en <= pwdata[16 +: NPIN];
        end
        OFS_MASK:
        begin
          thr_mask <= pwdata[NPIN-1:0];
          fast_mask <= pwdata[16 +: NPIN];
        end
        OFS_ANALOG: analog_sel <= pwdata[NPIN-1:0];
        default: ;
      endcase
    end
  end

  // threshold words, one per analog pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = FP; i <= NPIN; i++)
      begin
        thr_high[i] <= RST_THR_HIGH;
        thr_low[i] <= RST_THR_LOW;
      end
    end
    else if (wr)
    begin
      for (int i = FP; i <= NPIN; i++)
      begin
        if (paddr == OFS_THR_BASE + 8'(4 * (i - FP)))
        begin
          thr_high[i] <= pwdata[THR_HIGH_LSB +: 16];
          thr_low[i] <= pwdata[THR_LOW_LSB +: 16];
        end
      end
    end
  end

  // monitor start-up, only once enabled
  logic [4:0] init_cnt;
  logic init_done;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_cnt <= '0;
      init_done <= 1'b0;
    end
    else if (!ctrl[CTRL_CLK_MON_EN])
    begin
      init_cnt <= '0;
      init_done <= 1'b0;
    end
    else if (init_cnt == 5'(INIT_CYC))
      init_done <= 1'b1;
    else
      init_cnt <= init_cnt + 5'd1;
  end

  // count main ticks in a window of redundant ticks
  localparam logic [9:0] LIM_HI = 10'(CLK_WIN + CLK_WIN * FREQ_DIFF_PCT / 100);
  localparam logic [9:0] LIM_LO = 10'(CLK_WIN - CLK_WIN * FREQ_DIFF_PCT / 100);
  logic [8:0] win_cnt;
  logic [9:0] main_cnt;
  logic osc_bad;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_cnt <= '0;
      main_cnt <= '0;
    end
    else if (!init_done)
    begin
      win_cnt <= '0;
      main_cnt <= '0;
    end
    else if (red_edge && win_cnt == 9'(CLK_WIN - 1))
    begin
      win_cnt <= '0;
      main_cnt <= {9'h000, main_edge};
    end
    else
    begin
      if (red_edge)
        win_cnt <= win_cnt + 9'd1;
      if (main_edge && main_cnt != 10'h3FF)
        main_cnt <= main_cnt + 10'd1;
    end
  end
  // window end checks the count; an overrun fails at once
  assign osc_bad = init_done && ((main_cnt > LIM_HI) ||
    (red_edge && win_cnt == 9'(CLK_WIN - 1) && main_cnt < LIM_LO));

  // standby stuck detector, never gated by mode
  logic [6:0] stby_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stby_cnt <= '0;
    else if (stby_s != stby_d)
      stby_cnt <= '0;
    else if (stby_cnt != 7'(STUCK_CYC))
      stby_cnt <= stby_cnt + 7'd1;
  end
  wire stby_bad = (stby_cnt == 7'(STUCK_CYC));

  // regulator filters: condition must outlast the filter
  logic [6:0] uv_cnt [3];
  logic [6:0] ov_cnt [3];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int r = 0; r < 3; r++)
      begin
        uv_cnt[r] <= '0;
        ov_cnt[r] <= '0;
      end
    end
    else
    begin
      for (int r = 0; r < 3; r++)
      begin
        uv_cnt[r] <= !uv_s[r] ? 7'd0 :
          (uv_cnt[r] == 7'(REG_FILT_CYC)) ? uv_cnt[r] : uv_cnt[r] + 7'd1;
        ov_cnt[r] <= !ov_s[r] ? 7'd0 :
          (ov_cnt[r] == 7'(REG_FILT_CYC)) ? ov_cnt[r] : ov_cnt[r] + 7'd1;
      end
    end
  end

  // echo filters per pin; pin 9 exempt while it is sdo
  logic [4:0] echo_cnt [NPIN];
  logic [NPIN-1:0] short_hit, echo_chk;
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      echo_chk[p] = out_en[p] && !short_flag[p] && !analog_sel[p];
      if (p == NPIN - 1 && ctrl[CTRL_SPI_MODE])
        echo_chk[p] = 1'b0;
      short_hit[p] = echo_cnt[p] == 5'(ECHO_FILT_CYC);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < NPIN; p++)
        echo_cnt[p] <= '0;
    end
    else
    begin
      for (int p = 0; p < NPIN; p++)
      begin
        if (!echo_chk[p] || echo_s[p] == out_val[p])
          echo_cnt[p] <= '0;
        else if (!short_hit[p])
          echo_cnt[p] <= echo_cnt[p] + 5'd1;
      end
    end
  end

  // open-wire sequence: pulldown, settle, fast conversion
  typedef enum {OW_IDLE, OW_SETTLE, OW_CONV} cfm_ow_t;
  cfm_ow_t ow_state;
  logic [3:0] ow_pin;
  logic [7:0] ow_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ow_state <= OW_IDLE;
      ow_pin <= 4'(FP);
      ow_cnt <= '0;
      open_pulldown <= '0;
      open_req <= 1'b0;
    end
    else
    begin
      case (ow_state)
        OW_IDLE:
        begin
          ow_pin <= (ow_pin >= 4'(NPIN)) ? 4'(FP) : ow_pin + 4'd1;
          if (analog_sel[ow_pin - 4'd1] && ow_pin >= 4'(FP))
          begin
            open_pulldown[ow_pin - 4'd1] <= 1'b1;
            ow_pin <= ow_pin;
            ow_cnt <= '0;
            ow_state <= OW_SETTLE;
          end
        end
        OW_SETTLE:
          if (ow_cnt == 8'(OPEN_SET_CYC))
          begin
            open_req <= 1'b1;
            ow_state <= OW_CONV;
          end
          else
            ow_cnt <= ow_cnt + 8'd1;
        OW_CONV:
          if (conv.valid && conv.open_test)
          begin
            open_req <= 1'b0;
            open_pulldown <= '0;
            ow_pin <= (ow_pin >= 4'(NPIN)) ? 4'(FP) : ow_pin + 4'd1;
            ow_state <= OW_IDLE;
          end
        default: ow_state <= OW_IDLE;
      endcase
    end
  end

  // conversion evaluation
  wire [3:0] cp = conv.pin;
  wire conv_ok = conv.valid && cp >= 4'(FP) && cp <= 4'(NPIN) && analog_sel[cp - 4'd1];
  wire [15:0] c_high = thr_high[cp];
  wire [15:0] c_low = thr_low[cp];
  wire [15:0] c_fast = fast_thr(c_low, ctrl[CTRL_DELTA_LSB +: 4]);

  // fault latches: set wins over the read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {uv_flag, ov_flag, bist_flag, osc_fail, stby_fail} <= '0;
      {short_flag, open_flag, high_flag, low_flag, fast_flag} <= '0;
    end
    else
    begin
      if (rd_at(paddr, OFS_STATUS, rd)) {osc_fail, stby_fail} <= 2'b00;
      if (rd_at(paddr, OFS_REG_FAULT, rd)) {uv_flag, ov_flag} <= '0;
      if (rd_at(paddr, OFS_SELFTEST, rd)) bist_flag <= '0;
      if (rd_at(paddr, OFS_SHORT, rd)) short_flag <= '0;
      if (rd_at(paddr, OFS_OPEN, rd)) open_flag <= '0;
      if (rd_at(paddr, OFS_THR_FAULT, rd)) {high_flag, low_flag} <= '0;
      if (rd_at(paddr, OFS_FAST_FAULT, rd)) fast_flag <= '0;
      if (osc_bad) osc_fail <= 1'b1;
      if (stby_bad) stby_fail <= 1'b1;
      for (int r = 0; r < 3; r++)
      begin
        if (uv_cnt[r] == 7'(REG_FILT_CYC)) uv_flag[r] <= 1'b1;
        if (ov_cnt[r] == 7'(REG_FILT_CYC)) ov_flag[r] <= 1'b1;
        if (selftest_req && selftest_bad[r]) bist_flag[r] <= 1'b1;
      end
      for (int p = 0; p < NPIN; p++)
        if (short_hit[p]) short_flag[p] <= 1'b1;
      if (conv_ok && conv.open_test && conv.code < OPEN_THR)
        open_flag[cp - 4'd1] <= 1'b1;
      if (conv_ok && !conv.open_test && !thr_mask[cp - 4'd1])
      begin
        if (conv.code > c_high) high_flag[cp - 4'd1] <= 1'b1;
        if (conv.code < c_low) low_flag[cp - 4'd1] <= 1'b1;
      end
      if (conv_ok && !conv.open_test && !fast_mask[cp - 4'd1] && conv.code < c_fast)
        fast_flag[cp - 4'd1] <= 1'b1;
    end
  end

  // registered outputs
  wire any_fault = |{uv_flag, ov_flag, bist_flag, osc_fail, stby_fail, short_flag,
    open_flag, high_flag, low_flag, fast_flag};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_line <= 1'b0;
      config_override <= 1'b0;
      balance_en <= 1'b0;
      bootstrap_en <= 1'b0;
      wake_en <= 1'b1;
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      fault_line <= any_fault;
      config_override <= |{bist_flag, open_flag, high_flag, low_flag, fast_flag};
      balance_en <= !stby_fail && !uv_flag[REG_CORE] && !ov_flag[REG_CORE];
      bootstrap_en <= !ov_flag[REG_CORE];
      // stuck in low power loses the wake path; serial stays
      if (stby_bad && low_power) wake_en <= 1'b0;
      pin_out <= out_val;
      pin_oe <= out_en & ~short_flag & ~analog_sel;
    end
  end

  // apb read mux, zero wait state
  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = '0;
    case (paddr)
      OFS_CTRL: next_prdata = ctrl;
      OFS_STATUS: next_prdata = {26'h0, fault_line, wake_en, stby_fail, osc_fail,
        ctrl[CTRL_CLK_MON_EN], init_done};
      OFS_REG_FAULT: next_prdata = {26'h0, ov_flag, uv_flag};
      OFS_SELFTEST: next_prdata = {29'h0, bist_flag};
      OFS_GPIO_OUT: next_prdata = {7'h0, out_en, 7'h0, out_val};
      OFS_SHORT: next_prdata = {23'h0, short_flag};
      OFS_OPEN: next_prdata = {23'h0, open_flag};
      OFS_THR_FAULT: next_prdata = {7'h0, low_flag, 7'h0, high_flag};
      OFS_FAST_FAULT: next_prdata = {23'h0, fast_flag};
      OFS_MASK: next_prdata = {7'h0, fast_mask, 7'h0, thr_mask};
      OFS_ANALOG: next_prdata = {23'h0, analog_sel};
      default:
        for (int i = FP; i <= NPIN; i++)
          if (paddr == OFS_THR_BASE + 8'(4 * (i - FP)))
            next_prdata = {thr_high[i], thr_low[i]};
    endcase
  end
  assign prdata = next_prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule

// File: tb/cfm_monitor_checker.sv
`timescale 1ns/100ps
// watches the monitor ports only
module cfm_monitor_checker
  import cfm_pkg::*;
#(
  parameter int NPIN = 9
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire cfm_pkg::cfm_regcmp_t reg_cmp,
  input wire logic selftest_req,
  input wire logic [2:0] selftest_bad,
  input wire logic low_power,
  input wire logic standby_osc,
  input wire logic [NPIN-1:0] pin_echo,
  input wire cfm_pkg::cfm_conv_t conv,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] open_pulldown,
  input wire logic open_req,
  input wire logic fault_line,
  input wire logic config_override,
  input wire logic balance_en,
  input wire logic bootstrap_en,
  input wire logic wake_en
);
  logic [7:0] mism_cnt; // cycles pin 1 driven against its echo
  logic [7:0] ov_cnt; // core ov cycles, stops at 64
  logic [7:0] stby_cnt; // cycles without a standby edge
  logic stby_q; // last standby level
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // echo mismatch length, cleared once released
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mism_cnt <= 8'h00;
    else if (pin_oe[0] && (pin_echo[0] != pin_out[0]))
      mism_cnt <= mism_cnt + 8'h01;
    else
      mism_cnt <= 8'h00;
  end
  // core ov length, saturating so it cannot wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ov_cnt <= 8'h00;
    else if (!reg_cmp.ov[REG_CORE])
      ov_cnt <= 8'h00;
    else if (ov_cnt != 8'h40)
      ov_cnt <= ov_cnt + 8'h01;
  end
  // standby silence length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stby_cnt <= 8'h00;
    else if (standby_osc != stby_q)
      stby_cnt <= 8'h00;
    else if (stby_cnt != 8'hFF)
      stby_cnt <= stby_cnt + 8'h01;
  end
  // previous standby level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stby_q <= 1'h0;
    else
      stby_q <= standby_osc;
  end
  short_caught_a: assert property (mism_cnt < 8'd28)
    else $error("pin 1 short left driving");
  short_early_a: assert property ($fell(pin_oe[0]) |-> $past(mism_cnt) >= 8'd18)
    else $error("pin 1 released before filter time");
  core_ov_a: assert property (ov_cnt > 8'd46 |-> !bootstrap_en && !balance_en && fault_line)
    else $error("core overvoltage not acted on");
  stuck_bal_a: assert property (stby_cnt > 8'd72 |-> !balance_en)
    else $error("balancing on with stuck standby");
  wake_keep_a: assert property (!low_power && $past(!low_power) && wake_en |=> wake_en)
    else $error("wake path lost in normal mode");
  wake_stay_a: assert property (!wake_en |=> !wake_en)
    else $error("wake path came back before reset");
  selftest_fail_a: assert property (selftest_req && (selftest_bad != 3'h0) |->
    ##[1:4] (config_override && fault_line))
    else $error("self test failure not reported");
  open_settle_a: assert property ($rose(|open_pulldown) |-> !open_req [*8])
    else $error("open conversion asked before settling");
  open_fault_a: assert property (conv.valid && conv.open_test && open_req &&
    (conv.code < OPEN_THR) |-> ##[1:3] (config_override && fault_line))
    else $error("open wire not reported");
  pd_range_a: assert property (open_pulldown[1:0] == 2'h0)
    else $error("pulldown on a pin without open check");
  cover property (mism_cnt == 8'd20);
  cover property (open_req && conv.valid && conv.open_test);
  cover property (stby_cnt == 8'd70);
  cover property (ov_cnt == 8'd47);
endmodule

bind cfm_monitor cfm_monitor_checker #(.NPIN(NPIN)) chk_u (
  .pclk(pclk), .presetn(presetn), .reg_cmp(reg_cmp), .selftest_req(selftest_req),
  .selftest_bad(selftest_bad), .low_power(low_power), .standby_osc(standby_osc),
  .pin_echo(pin_echo), .conv(conv), .pin_out(pin_out), .pin_oe(pin_oe),
  .open_pulldown(open_pulldown), .open_req(open_req), .fault_line(fault_line),
  .config_override(config_override), .balance_en(balance_en),
  .bootstrap_en(bootstrap_en), .wake_en(wake_en)
);

// File: tb/cfm_host.sv
`timescale 1ns/100ps
// host controller as an apb master
module cfm_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata
);
  // bus idle from time zero
  initial
    {paddr, psel, penable, pwrite, pwdata} = '0;
  // setup, access held until ready, data taken at that same edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// File: tb/test_cfm_monitor.sv
`timescale 1ns/100ps
module test_cfm_monitor;
  import cfm_pkg::*;
  // row: code, mask, expected latches, fault
  typedef struct packed {
    logic [15:0] code;
    logic [31:0] mask;
    logic [31:0] thr;
    logic [31:0] fast;
    logic flt;
  } cfm_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic red_osc_tick, main_osc_tick, standby_osc, selftest_req, low_power;
  logic slow_main, stby_stop; // main clock halved, standby frozen
  logic [2:0] selftest_bad;
  logic [3:0] div; // oscillator divider
  logic [8:0] pin_echo, pin_out, pin_oe, open_pulldown, short_inj;
  logic open_req, fault_line, config_override, balance_en, bootstrap_en, wake_en;
  cfm_regcmp_t reg_cmp;
  cfm_conv_t conv;
  int mismatches, checks_done, cycles, n;
  cfm_row_t rows [8];
  cfm_monitor dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .red_osc_tick(red_osc_tick),
    .main_osc_tick(main_osc_tick), .standby_osc(standby_osc), .reg_cmp(reg_cmp),
    .selftest_req(selftest_req), .selftest_bad(selftest_bad), .low_power(low_power),
    .pin_echo(pin_echo), .conv(conv), .pin_out(pin_out), .pin_oe(pin_oe),
    .open_pulldown(open_pulldown), .open_req(open_req), .fault_line(fault_line),
    .config_override(config_override), .balance_en(balance_en),
    .bootstrap_en(bootstrap_en), .wake_en(wake_en));
  cfm_host host_u (.pclk(pclk), .pready(pready), .prdata(prdata), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  // oscillators, echo with shorts, hang limit
  always @(posedge pclk)
  begin
    div <= div + 4'h1;
    red_osc_tick <= div[1];
    main_osc_tick <= slow_main ? div[2] : div[1];
    standby_osc <= stby_stop ? standby_osc : div[2];
    pin_echo <= pin_out ^ short_inj;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word(32'(got), 32'(exp));
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(a, 1'h1, d, q);
  endtask
  // read, compare masked
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host_u.xfer(a, 1'h0, 32'h0, q);
    cmp_word(q & m, e);
  endtask
  // one-cycle conversion result for pin 3
  task automatic send(input logic ot, input logic [15:0] c);
    conv <= {1'h1, ot, 4'h3, c};
    step(1);
    conv.valid <= 1'h0;
  endtask
  task automatic rst();
    presetn <= 1'h0;
    step(2);
    presetn <= 1'h1;
    step(1);
  endtask
  // comparator held past its filter, then released
  task automatic reg_case(input logic [5:0] c, input logic [31:0] e, input logic boot);
    reg_cmp <= c;
    step(50);
    reg_cmp <= '0;
    step(3);
    cmp_bit(balance_en, 1'h0);
    cmp_bit(bootstrap_en, boot);
    cmp_bit(fault_line, 1'h1);
    rd(OFS_REG_FAULT, '1, e);
  endtask
  task automatic done(input string s);
    $display("test %0s finished", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {presetn, selftest_req} = '0;
    {low_power, slow_main, stby_stop, selftest_bad, div, pin_echo, short_inj} = '0;
    reg_cmp = '0;
    conv = '0;
    {mismatches, checks_done, cycles} = '0;
    // thresholds high 8000, low 2000, delta 2 gives fast 2020
    rows[0] = '{16'h9000, 32'h0, 32'h4, 32'h0, 1'h1};
    rows[1] = '{16'h1000, 32'h0, 32'h4_0000, 32'h4, 1'h1};
    rows[2] = '{16'h2010, 32'h0, 32'h0, 32'h4, 1'h1};
    rows[3] = '{16'h2020, 32'h0, 32'h0, 32'h0, 1'h0};
    rows[4] = '{16'h8000, 32'h0, 32'h0, 32'h0, 1'h0};
    rows[5] = '{16'h9000, 32'h4, 32'h0, 32'h0, 1'h0};
    rows[6] = '{16'h2010, 32'h4_0000, 32'h0, 32'h0, 1'h0};
    rows[7] = '{16'h1000, 32'h4_0004, 32'h0, 32'h0, 1'h0};
    step(4);
    presetn <= 1'h1;
    step(1);
    cmp_bit(wake_en, 1'h1);
    rd(OFS_CTRL, '1, RST_CTRL);
    rd(OFS_THR_BASE, '1, {RST_THR_HIGH, RST_THR_LOW});
    rd(8'h3C, '1, 32'h0);
    rd(OFS_STATUS, 32'h1, 32'h0);
    wr(OFS_CTRL, 32'h1);
    step(1200);
    rd(OFS_STATUS, 32'h5, 32'h1);
    done("clock monitor start");
    wr(OFS_ANALOG, 32'h4);
    wr(OFS_THR_BASE, 32'h8000_2000);
    wr(OFS_CTRL, 32'h20);
    rd(OFS_THR_BASE, '1, 32'h8000_2000);
    foreach (rows[i])
    begin
      wr(OFS_MASK, rows[i].mask);
      send(1'h0, rows[i].code);
      step(4);
      cmp_bit(fault_line, rows[i].flt);
      rd(OFS_THR_FAULT, '1, rows[i].thr);
      rd(OFS_FAST_FAULT, '1, rows[i].fast);
    end
    done("thresholds");
    for (n = 0; n < 400 && open_req !== 1'h1; n++)
      step(1);
    cmp_word({23'h0, open_pulldown}, 32'h4);
    send(1'h1, 16'h0100);
    step(4);
    cmp_bit(config_override, 1'h1);
    rd(OFS_OPEN, '1, 32'h4);
    rd(OFS_OPEN, '1, 32'h0);
    done("open wire");
    rst();
    wr(OFS_CTRL, 32'h2);
    wr(OFS_GPIO_OUT, 32'h0101_0101);
    short_inj <= 9'h101;
    step(40);
    cmp_word({23'h0, pin_oe}, 32'h100);
    cmp_bit(fault_line, 1'h1);
    wr(OFS_GPIO_OUT, 32'h0101_0100);
    short_inj <= 9'h000;
    rd(OFS_SHORT, '1, 32'h1);
    rd(OFS_SHORT, '1, 32'h0);
    wr(OFS_GPIO_OUT, 32'h0101_0101);
    step(4);
    cmp_word({23'h0, pin_oe}, 32'h101);
    done("output short");
    reg_cmp <= 6'h08;
    step(30);
    reg_cmp <= '0;
    step(5);
    rd(OFS_REG_FAULT, '1, 32'h0);
    reg_case(6'h04, 32'h20, 1'h0);
    reg_case(6'h20, 32'h04, 1'h1);
    selftest_req <= 1'h1;
    selftest_bad <= 3'h2;
    step(2);
    selftest_req <= 1'h0;
    selftest_bad <= 3'h0;
    step(4);
    cmp_bit(config_override, 1'h1);
    rd(OFS_SELFTEST, '1, 32'h2);
    done("regulators");
    wr(OFS_CTRL, 32'h1);
    slow_main <= 1'h1;
    step(3000);
    rd(OFS_STATUS, 32'h4, 32'h4);
    stby_stop <= 1'h1;
    step(80);
    cmp_bit(balance_en, 1'h0);
    cmp_bit(wake_en, 1'h1);
    rd(OFS_CTRL, '1, 32'h1);
    low_power <= 1'h1;
    step(5);
    cmp_bit(wake_en, 1'h0);
    done("oscillator faults");
    report_and_stop();
  end
endmodule
